// ==== hdl/lsiu_pkg.sv ====
package lsiu_pkg;

  // sizes of the register set
  localparam int LSIU_NSTS = 9;                 // number of status registers
  localparam int LSIU_W    = 8;                 // register data width

  // register indices; byte address on the bus is four times the index
  localparam logic [7:0] LSIU_IDX_SUM_LO   = 8'h14;
  localparam logic [7:0] LSIU_IDX_SUM_HI   = 8'h15;
  localparam logic [7:0] LSIU_IDX_STS_BASE = 8'h20;  // status 1..9
  localparam logic [7:0] LSIU_IDX_MSK_BASE = 8'h30;  // masks 1..9
  localparam logic [7:0] LSIU_IDX_FIFTH_INFORMATION_REG    = 8'h40;
  localparam logic [7:0] LSIU_IDX_SIXTH_INFORMATION_REG    = 8'h41;
  localparam logic [7:0] LSIU_IDX_LIVE     = 8'h42;

  // reset value of every writable and readable register
  localparam logic [7:0] LSIU_RST_VAL = 8'h00;

  // bit kinds: condition bits of the sync status register (loss of sync at
  // bit 0 is a condition, regained sync at bit 4 is an event)
  localparam logic [8:0][7:0] LSIU_STS_COND_DEF =
    72'h00_00_00_00_00_00_00_01_00;
  localparam logic [8:0][7:0] LSIU_STS_DBL_DEF  =
    72'h00_00_00_00_00_00_00_00_00;
  localparam logic [7:0]      LSIU_FIFTH_INFORMATION_REG_LIVE_DEF = 8'hF0;
  localparam logic [7:0]      LSIU_SIXTH_INFORMATION_REG_LIVE_DEF = 8'hF0;

  // bus carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } lsiu_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } lsiu_apb_rsp_s;

  // state of one latched register
  typedef struct packed {
    logic [7:0] latch;   // sticky copy, set by hardware
    logic [7:0] rdcopy;  // copy that software reads
    logic [7:0] prev;    // input one cycle ago
  } lsiu_cell_s;

  // state of the top level
  typedef struct packed {
    logic [8:0][7:0] mask;
    logic [7:0]      live;
    logic            irq;
  } lsiu_top_s;

endpackage

// ==== hdl/lsiu_latch_cell.sv ====
`timescale 1ns/1ps
module lsiu_latch_cell
  import lsiu_pkg::*;
#(
  parameter int         W         = 8,
  parameter logic [7:0] DBL_MASK  = 8'h00,
  parameter logic [7:0] LIVE_MASK = 8'h00
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] sig_in,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_byte,
  output logic      [7:0] latch_out,
  output logic      [7:0] rd_out
);

  if (W != LSIU_W) begin : g_bad_width
    $error("lsiu_latch_cell: only 8-bit registers are supported");
  end

  lsiu_cell_s q;
  lsiu_cell_s d;
  logic [7:0] fall;
  logic [7:0] setv;

  // condition bits are levels, event bits pulses; both simply set the latch
  // while high, so a condition still present sets it again after a read
  always_comb begin
    d    = q;
    fall = q.prev & ~sig_in;
    setv = (sig_in & ~LIVE_MASK) | (fall & DBL_MASK);
    d.prev = sig_in;
    if (wr_en) begin
      // selected bits refresh and clear; unselected bits hold
      d.rdcopy = (q.rdcopy & ~wr_byte)
               | ((q.latch | setv) & wr_byte);
      d.latch  = (q.latch & ~wr_byte) | setv;  // set wins over clear
    end else begin
      d.latch = q.latch | setv;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign latch_out = q.latch;
  // unlatched bits show the live input and need no selecting write
  assign rd_out = (q.rdcopy & ~LIVE_MASK) | (q.prev & LIVE_MASK);

  property p_set_latches;
    @(posedge ref_clk) disable iff (!rst_b)
      (|setv) |=> ((q.latch & $past(setv)) == $past(setv));
  endproperty
  a_set_latches: assert property (p_set_latches)
    else $error("a set input did not latch");

  property p_refresh_sel;
    @(posedge ref_clk) disable iff (!rst_b)
      wr_en |=> ((q.rdcopy & $past(wr_byte)) ==
                 (($past(q.latch) | $past(setv)) & $past(wr_byte)));
  endproperty
  a_refresh_sel: assert property (p_refresh_sel)
    else $error("selected bits not refreshed");

  property p_hold_unsel;
    @(posedge ref_clk) disable iff (!rst_b)
      wr_en |=> ((q.rdcopy & ~$past(wr_byte)) ==
                 ($past(q.rdcopy) & ~$past(wr_byte)));
  endproperty
  a_hold_unsel: assert property (p_hold_unsel)
    else $error("unselected bits changed");

  property p_clear_on_read;
    @(posedge ref_clk) disable iff (!rst_b)
      (wr_en && ((wr_byte & setv) == 8'h00)) |=>
        ((q.latch & $past(wr_byte)) == 8'h00);
  endproperty
  a_clear_on_read: assert property (p_clear_on_read)
    else $error("read bit was not cleared");

  property p_double_edge;
    @(posedge ref_clk) disable iff (!rst_b)
      (|(fall & DBL_MASK)) |=> ((q.latch & $past(fall) & DBL_MASK) != 8'h00);
  endproperty
  a_double_edge: assert property (p_double_edge)
    else $error("clearing edge of double bit not latched");

endmodule

// ==== hdl/lsiu_apb_port.sv ====
`timescale 1ns/1ps
module lsiu_apb_port
  import lsiu_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst_b,
  input  lsiu_apb_req_s      apb_req,
  input  wire logic [7:0]    rd_data,
  input  wire logic          addr_ok,
  output lsiu_apb_rsp_s      apb_rsp,
  output logic               wr_go
);

  lsiu_apb_rsp_s q;
  lsiu_apb_rsp_s d;
  logic          setup;

  // answer is prepared in the setup cycle, so every access has no wait
  always_comb begin
    d        = q;
    setup    = apb_req.psel & ~apb_req.penable;
    d.pready = 1'b0;
    if (setup) begin
      d.pready  = 1'b1;
      d.pslverr = ~addr_ok;
      d.prdata  = (addr_ok && !apb_req.pwrite) ? {24'h000000, rd_data}
                                               : 32'h00000000;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign apb_rsp = q;
  // write commits only at the edge that completes the access
  assign wr_go = apb_req.psel & apb_req.penable & apb_req.pwrite & q.pready;

  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence

  property p_one_wait_free;
    @(posedge ref_clk) disable iff (!rst_b)
      s_setup |=> q.pready ##1 !q.pready;
  endproperty
  a_one_wait_free: assert property (p_one_wait_free)
    else $error("pready not a single cycle after setup");

endmodule

// ==== hdl/lsiu_top.sv ====
`timescale 1ns/1ps
module lsiu_top
  import lsiu_pkg::*;
#(
  parameter logic [8:0][7:0] STS_COND   = LSIU_STS_COND_DEF,
  parameter logic [8:0][7:0] STS_DBL    = LSIU_STS_DBL_DEF,
  parameter logic [7:0]      FIFTH_INFORMATION_REG_LIVE = LSIU_FIFTH_INFORMATION_REG_LIVE_DEF,
  parameter logic [7:0]      SIXTH_INFORMATION_REG_LIVE = LSIU_SIXTH_INFORMATION_REG_LIVE_DEF
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  lsiu_apb_req_s         apb_req,
  output lsiu_apb_rsp_s         apb_rsp,
  input  wire logic [8:0][7:0]  sts_in,
  input  wire logic [7:0]       fifth_information_reg_in,
  input  wire logic [7:0]       sixth_information_reg_in,
  input  wire logic [7:0]       live_sync_in,
  output logic                  irq
);

  if ((STS_DBL & ~STS_COND) != '0) begin : g_bad_dbl
    $error("lsiu_top: double-interrupt bits must be condition bits");
  end

  lsiu_top_s       q;
  lsiu_top_s       d;
  logic [7:0]      idx;
  logic            align_ok;
  logic            wr_go;
  logic            rd_hit;
  logic            wr_hit;
  logic [7:0]      rd_data;
  logic [7:0]      wbyte;
  logic [8:0][7:0] sts_latch;
  logic [8:0][7:0] sts_rd;
  logic [8:0]      sts_wr;
  logic [8:0]      sts_pend;
  logic [7:0]      fifth_information_reg_rd;
  logic [7:0]      sixth_information_reg_rd;
  logic            fifth_information_reg_wr;
  logic            sixth_information_reg_wr;
  logic [7:0]      sum_lo;
  logic [7:0]      sum_hi;

  // index decode; low address bits must be zero for an aligned word
  assign idx      = apb_req.paddr[9:2];
  assign align_ok = (apb_req.paddr[1:0] == 2'b00)
                  & (apb_req.paddr[11:10] == 2'b00);
  assign wbyte    = apb_req.pwdata[7:0];

  lsiu_apb_port u_apb (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .apb_req (apb_req),
    .rd_data (rd_data),
    .addr_ok (apb_req.pwrite ? wr_hit : rd_hit),
    .apb_rsp (apb_rsp),
    .wr_go   (wr_go)
  );

  // one latched status register and its pending flag per index
  for (genvar k = 0; k < LSIU_NSTS; k++) begin : g_sts
    assign sts_wr[k] = wr_go & align_ok
                     & (idx == LSIU_IDX_STS_BASE + 8'(k));
    lsiu_latch_cell #(
      .W         (LSIU_W),
      .DBL_MASK  (STS_DBL[k]),
      .LIVE_MASK (8'h00)
    ) u_cell (
      .ref_clk   (ref_clk),
      .rst_b     (rst_b),
      .sig_in    (sts_in[k]),
      .wr_en     (sts_wr[k]),
      .wr_byte   (wbyte),
      .latch_out (sts_latch[k]),
      .rd_out    (sts_rd[k])
    );
    // the sticky latch, not the read copy, drives the interrupt
    assign sts_pend[k] = |(sts_latch[k] & q.mask[k]);
  end

  // information registers latch their bits outside the live mask the same way but feed nothing onward
  assign fifth_information_reg_wr = wr_go & align_ok & (idx == LSIU_IDX_FIFTH_INFORMATION_REG);
  assign sixth_information_reg_wr = wr_go & align_ok & (idx == LSIU_IDX_SIXTH_INFORMATION_REG);

  lsiu_latch_cell #(
    .W         (LSIU_W),
    .DBL_MASK  (8'h00),
    .LIVE_MASK (FIFTH_INFORMATION_REG_LIVE)
  ) u_fifth_information_reg (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .sig_in    (fifth_information_reg_in),
    .wr_en     (fifth_information_reg_wr),
    .wr_byte   (wbyte),
    .latch_out (),
    .rd_out    (fifth_information_reg_rd)
  );

  lsiu_latch_cell #(
    .W         (LSIU_W),
    .DBL_MASK  (8'h00),
    .LIVE_MASK (SIXTH_INFORMATION_REG_LIVE)
  ) u_sixth_information_reg (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .sig_in    (sixth_information_reg_in),
    .wr_en     (sixth_information_reg_wr),
    .wr_byte   (wbyte),
    .latch_out (),
    .rd_out    (sixth_information_reg_rd)
  );

  // summaries: one flag per status register, ninth one on its own
  assign sum_lo = sts_pend[7:0];
  assign sum_hi = {7'h00, sts_pend[8]};

  // read mux and write decode; the summaries and live register are
  // read-only, so a write to them is refused with an error
  always_comb begin
    rd_data = 8'h00;
    rd_hit  = 1'b0;
    wr_hit  = 1'b0;
    for (int k = 0; k < LSIU_NSTS; k++) begin
      if (idx == LSIU_IDX_STS_BASE + 8'(k)) begin
        rd_data = sts_rd[k];
        rd_hit  = 1'b1;
        wr_hit  = 1'b1;
      end
      if (idx == LSIU_IDX_MSK_BASE + 8'(k)) begin
        rd_data = q.mask[k];
        rd_hit  = 1'b1;
        wr_hit  = 1'b1;
      end
    end
    case (idx)
      LSIU_IDX_SUM_LO: begin
        rd_data = sum_lo;
        rd_hit  = 1'b1;
      end
      LSIU_IDX_SUM_HI: begin
        rd_data = sum_hi;
        rd_hit  = 1'b1;
      end
      LSIU_IDX_FIFTH_INFORMATION_REG: begin
        rd_data = fifth_information_reg_rd;
        rd_hit  = 1'b1;
        wr_hit  = 1'b1;
      end
      LSIU_IDX_SIXTH_INFORMATION_REG: begin
        rd_data = sixth_information_reg_rd;
        rd_hit  = 1'b1;
        wr_hit  = 1'b1;
      end
      LSIU_IDX_LIVE: begin
        rd_data = q.live;
        rd_hit  = 1'b1;
      end
      default: begin
      end
    endcase
    rd_hit = rd_hit & align_ok;
    wr_hit = wr_hit & align_ok;
  end

  // masks, live synchronizer copy and the registered interrupt
  always_comb begin
    d      = q;
    d.live = live_sync_in;
    for (int k = 0; k < LSIU_NSTS; k++) begin
      if (wr_go && align_ok && idx == LSIU_IDX_MSK_BASE + 8'(k)) begin
        d.mask[k] = wbyte;
      end
    end
    d.irq = |sts_pend;
  end

  // masks come up zero, so nothing can interrupt until software opens them
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign irq = q.irq;

  // helper: cycles since reset release, saturating, for the reset check
  logic [1:0] rel_cnt_q;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rel_cnt_q <= 2'b00;
    end else if (rel_cnt_q != 2'b11) begin
      rel_cnt_q <= rel_cnt_q + 2'b01;
    end
  end

  property p_irq_tracks;
    @(posedge ref_clk) disable iff (!rst_b)
      1'b1 |=> (irq == ($past(sts_pend) != '0));
  endproperty
  a_irq_tracks: assert property (p_irq_tracks)
    else $error("interrupt does not follow pending status");

  property p_mask_gates;
    @(posedge ref_clk) disable iff (!rst_b)
      (q.mask == '0) |=> !irq;
  endproperty
  a_mask_gates: assert property (p_mask_gates)
    else $error("interrupt with all masks clear");

  property p_reset_quiet;
    @(posedge ref_clk) disable iff (!rst_b)
      (rel_cnt_q == 2'b00) |-> (q.mask == '0) && !irq;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("masks or interrupt not clear after reset");

  property p_info_silent;
    @(posedge ref_clk) disable iff (!rst_b)
      ((sts_latch == '0) ##1 (sts_latch == '0)) |-> !irq;
  endproperty
  a_info_silent: assert property (p_info_silent)
    else $error("interrupt without any status bit");

  property p_summary;
    @(posedge ref_clk) disable iff (!rst_b)
      (sum_lo[0] == |(sts_latch[0] & q.mask[0]))
      && (sum_hi == {7'h00, |(sts_latch[8] & q.mask[8])});
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary flags disagree with status");

  property p_cond_reread;
    @(posedge ref_clk) disable iff (!rst_b)
      (sts_wr[1] && wbyte[0] && sts_in[1][0] && STS_COND[1][0])
        |=> sts_latch[1][0];
  endproperty
  a_cond_reread: assert property (p_cond_reread)
    else $error("condition bit lost while condition present");

  property p_live_read;
    @(posedge ref_clk) disable iff (!rst_b)
      1'b1 |=> (q.live == $past(live_sync_in));
  endproperty
  a_live_read: assert property (p_live_read)
    else $error("live synchronizer copy stale");

  // register accesses opened in this cycle, for the answer checks below
  sequence s_rd_live;
    apb_req.psel && !apb_req.penable && !apb_req.pwrite && align_ok
      && (idx == LSIU_IDX_LIVE);
  endsequence

  sequence s_wr_summary;
    apb_req.psel && !apb_req.penable && apb_req.pwrite
      && (idx == LSIU_IDX_SUM_LO || idx == LSIU_IDX_SUM_HI);
  endsequence

  // an open source on status 1 with its mask left alone this cycle
  sequence s_src_open;
    (|(sts_in[0] & q.mask[0]))
      && !(wr_go && align_ok && idx == LSIU_IDX_MSK_BASE);
  endsequence

  property p_live_data;
    @(posedge ref_clk) disable iff (!rst_b)
      s_rd_live |=> (apb_rsp.prdata == {24'h000000, $past(q.live)});
  endproperty
  a_live_data: assert property (p_live_data)
    else $error("live register read returned stale data");

  property p_ro_refused;
    @(posedge ref_clk) disable iff (!rst_b)
      s_wr_summary |=> apb_rsp.pslverr;
  endproperty
  a_ro_refused: assert property (p_ro_refused)
    else $error("write to a summary register was accepted");

  // latch one edge after the source, pin one edge after the latch
  property p_src_to_irq;
    @(posedge ref_clk) disable iff (!rst_b)
      s_src_open |=> ##1 irq;
  endproperty
  a_src_to_irq: assert property (p_src_to_irq)
    else $error("open source did not reach the interrupt");

  // latches come out of reset clear, not only the masks
  property p_reset_latch;
    @(posedge ref_clk) disable iff (!rst_b)
      (rel_cnt_q == 2'b00) |-> (sts_latch == '0);
  endproperty
  a_reset_latch: assert property (p_reset_latch)
    else $error("status latch not clear after reset");

endmodule

// ==== testbench/lsiu_host.sv ====
`timescale 1ns/1ps
module lsiu_host
  import lsiu_pkg::*;
(
  input  wire logic    ref_clk,
  input  lsiu_apb_rsp_s apb_rsp,
  output lsiu_apb_req_s apb_req
);
  int n_tmo;  // transfers whose answer never came

  // bus idle from time zero, so nothing is requested during reset
  initial begin
    apb_req = '0;
    n_tmo = 0;
  end

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic xfer(input  logic        wr,
                      input  logic [7:0]  idx,
                      input  logic [7:0]  wd,
                      output logic [31:0] rd,
                      output logic        err);
    int i;
    @(posedge ref_clk);
    apb_req.psel    <= 1'h1;
    apb_req.penable <= 1'h0;
    apb_req.pwrite  <= wr;
    apb_req.paddr   <= {2'h0, idx, 2'h0};  // byte address is four times index
    apb_req.pwdata  <= {24'h000000, wd};
    @(posedge ref_clk);
    apb_req.penable <= 1'h1;
    // pready is looked at on rising edges only, where the slave commits
    for (i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      if (apb_rsp.pready === 1'h1) begin
        break;
      end
    end
    if (i == 16) begin
      n_tmo++;
    end
    // answer taken at the completing edge, request released right after it
    rd  = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel    <= 1'h0;
    apb_req.penable <= 1'h0;
  endtask

  // selection write, then a read of the same register straight after
  task automatic sel_rd(input  logic [7:0]  idx,
                        input  logic [7:0]  sel,
                        output logic [31:0] rd);
    logic e;
    xfer(1'h1, idx, sel, rd, e);
    xfer(1'h0, idx, 8'h00, rd, e);
  endtask
endmodule

// ==== testbench/lsiu_tb_top.sv ====
`timescale 1ns/1ps
module lsiu_tb_top
  import lsiu_pkg::*;
;
  logic            ref_clk;
  logic            rst_b;
  logic            irq;
  lsiu_apb_req_s   apb_req;
  lsiu_apb_rsp_s   apb_rsp;
  logic [8:0][7:0] sts_in;
  logic [7:0]      fifth_information_reg_in;
  logic [7:0]      sixth_information_reg_in;
  logic [7:0]      live_sync_in;
  logic [31:0]     rd;
  logic            er;
  int              n_fail;
  int              checks_done;
  localparam logic [7:0] SB = LSIU_IDX_STS_BASE;
  localparam logic [7:0] MB = LSIU_IDX_MSK_BASE;
  // status 3 bit 0 made a double-interrupt condition bit
  localparam logic [8:0][7:0] DBL = 72'h00_00_00_00_00_00_01_00_00;

  lsiu_top #(
    .STS_COND (LSIU_STS_COND_DEF | DBL),
    .STS_DBL  (DBL)
  ) lsiu_top_i (
    .ref_clk      (ref_clk),
    .rst_b        (rst_b),
    .apb_req      (apb_req),
    .apb_rsp      (apb_rsp),
    .sts_in       (sts_in),
    .fifth_information_reg_in     (fifth_information_reg_in),
    .sixth_information_reg_in     (sixth_information_reg_in),
    .live_sync_in (live_sync_in),
    .irq          (irq)
  );

  lsiu_host lsiu_host_i (
    .ref_clk (ref_clk),
    .apb_rsp (apb_rsp),
    .apb_req (apb_req)
  );

  // 40 MHz clock
  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: got %h expected %h",
               $time, seen, exp);
    end
  endtask

  task automatic rd8(input logic [7:0] idx, input logic [7:0] exp);
    lsiu_host_i.xfer(1'h0, idx, 8'h00, rd, er);
    chk(rd, {24'h000000, exp});
    chk({31'h0, er}, 32'h0);
  endtask

  task automatic wr8(input logic [7:0] idx, input logic [7:0] d);
    lsiu_host_i.xfer(1'h1, idx, d, rd, er);
    chk({31'h0, er}, 32'h0);
  endtask

  task automatic sr(input logic [7:0] idx, input logic [7:0] s,
                    input logic [7:0] exp);
    lsiu_host_i.sel_rd(idx, s, rd);
    chk(rd, {24'h000000, exp});
  endtask

  // source to irq takes two edges; three leave margin, then settle
  task automatic irq_is(input logic e);
    repeat (3) @(posedge ref_clk);
    #1;
    chk({31'h0, irq}, {31'h0, e});
  endtask

  // one-cycle event pulse on a status source
  task automatic pulse(input int k, input logic [7:0] b);
    @(posedge ref_clk);
    sts_in[k] <= b;
    @(posedge ref_clk);
    sts_in[k] <= 8'h00;
  endtask

  task automatic conclude();
    n_fail += lsiu_host_i.n_tmo;
    $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // a hang anywhere, or a bus answer that never came, ends the run failed
  initial begin
    for (int c = 0; c < 20000; c++) begin
      @(posedge ref_clk);
      if (lsiu_host_i.n_tmo != 0) begin
        break;
      end
    end
    n_fail++;
    conclude();
  end

  initial begin
    n_fail = 0;
    checks_done = 0;
    rst_b = 1'h0;
    sts_in = '0;
    fifth_information_reg_in = 8'h00;
    sixth_information_reg_in = 8'h00;
    live_sync_in = 8'h00;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'h1;
    for (int k = 0; k < 9; k++) rd8(MB + k[7:0], 8'h00);
    rd8(LSIU_IDX_SUM_LO, 8'h00);
    irq_is(1'h0);
    $display("test reset done");
    // event latched while masked stays quiet
    pulse(0, 8'h02);
    irq_is(1'h0);
    rd8(LSIU_IDX_SUM_LO, 8'h00);
    wr8(MB, 8'h02);
    irq_is(1'h1);
    rd8(LSIU_IDX_SUM_LO, 8'h01);
    sr(SB, 8'h02, 8'h02);
    irq_is(1'h0);
    rd8(SB, 8'h02);
    sr(SB, 8'h00, 8'h02);
    sr(SB, 8'h02, 8'h00);
    $display("test event done");
    // condition bit with separate clearing event
    @(posedge ref_clk);
    sts_in[1] <= 8'h01;
    sr(SB + 8'h01, 8'h01, 8'h01);
    sr(SB + 8'h01, 8'h01, 8'h01);
    @(posedge ref_clk);
    sts_in[1] <= 8'h00;
    pulse(1, 8'h10);
    sr(SB + 8'h01, 8'h11, 8'h11);
    sr(SB + 8'h01, 8'h11, 8'h00);
    $display("test condition done");
    // all nine registers pending, handler masks and restores
    for (int k = 0; k < 9; k++) wr8(MB + k[7:0], 8'h01);
    for (int k = 0; k < 9; k++) pulse(k, 8'h01);
    irq_is(1'h1);
    rd8(LSIU_IDX_SUM_LO, 8'hFF);
    rd8(LSIU_IDX_SUM_HI, 8'h01);
    for (int k = 0; k < 9; k++) wr8(MB + k[7:0], 8'h00);
    irq_is(1'h0);
    rd8(LSIU_IDX_SUM_HI, 8'h00);
    for (int k = 0; k < 9; k++) wr8(MB + k[7:0], 8'h01);
    irq_is(1'h1);
    for (int k = 0; k < 9; k++) sr(SB + k[7:0], 8'h01, 8'h01);
    irq_is(1'h0);
    $display("test summary done");
    // double-interrupt bit of status 3 latches again as its condition ends
    @(posedge ref_clk);
    sts_in[2] <= 8'h01;
    irq_is(1'h1);
    sr(SB + 8'h02, 8'h01, 8'h01);
    @(posedge ref_clk);
    sts_in[2] <= 8'h00;
    sr(SB + 8'h02, 8'h01, 8'h01);
    irq_is(1'h0);
    sr(SB + 8'h02, 8'h01, 8'h00);
    $display("test double done");
    // information and live registers, never interrupting
    @(posedge ref_clk);
    fifth_information_reg_in <= 8'h11;
    sixth_information_reg_in <= 8'h20;
    live_sync_in <= 8'hA5;
    @(posedge ref_clk);
    fifth_information_reg_in <= 8'h10;
    irq_is(1'h0);
    rd8(LSIU_IDX_FIFTH_INFORMATION_REG, 8'h10);
    rd8(LSIU_IDX_SIXTH_INFORMATION_REG, 8'h20);
    sr(LSIU_IDX_FIFTH_INFORMATION_REG, 8'h01, 8'h11);
    rd8(LSIU_IDX_LIVE, 8'hA5);
    $display("test information done");
    // refused accesses: read-only summary and an unmapped index
    lsiu_host_i.xfer(1'h1, LSIU_IDX_SUM_LO, 8'hFF, rd, er);
    chk({31'h0, er}, 32'h1);
    rd8(LSIU_IDX_SUM_LO, 8'h00);
    lsiu_host_i.xfer(1'h0, 8'h50, 8'h00, rd, er);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    $display("test refusal done");
    conclude();
  end
endmodule
